// ===== rtl/ces_sequencer.sv
// exception sequencer and instruction clock accounting of the 16-bit core
`timescale 1ns/1ns
`include "ces_params.svh"

module ces_sequencer
	import ces_pkg::*;
#(
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic I_MCLK,
	input wire logic I_RESET,
	// asynchronous exception pins
	input wire logic I_RST_REQ,
	input wire logic I_BERR,
	input wire logic I_BKPT,
	input wire logic [2:0] I_IRQ_LEVEL,
	// core state and synchronous requests
	input wire logic I_BOUNDARY,
	input wire ces_sync_t I_SYNC_REQ,
	input wire logic [2:0] I_IRQ_MASK,
	input wire logic [23:0] I_PC,
	input wire logic [15:0] I_COND_CODES,
	input wire logic [15:0] I_SP,
	input wire logic [3:0] I_STACK_BANK,
	input wire logic I_RETURN,
	input wire logic [23:0] I_RETURN_ADDR,
	input wire ces_timing_t I_TIMING,
	// bus master
	output ces_bus_t O_BUS,
	input wire logic I_BUS_ACK,
	input wire logic I_BUS_BERR,
	input wire logic I_BUS_AUTOVEC,
	input wire logic [15:0] I_BUS_RDATA,
	// results to the core
	output logic O_BUSY,
	output logic O_LOAD,
	output logic O_RST_LOAD,
	output logic O_DEBUG,
	output logic [23:0] O_NEW_PC,
	output logic [15:0] O_NEW_SP,
	output logic [11:0] O_RST_EXT,
	output logic [15:0] O_RST_INDEX,
	output logic [7:0] O_VEC_NUM,
	output logic O_RETURN_VALID,
	output logic [23:0] O_RETURN_PC,
	output logic [CNT_W-1:0] O_INSN_CLKS
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (CNT_W < 8) begin : g_bad_width
		$error("CNT_W must be at least 8");
	end

	// ----------------------------------------------------------------
	// synchronisers for the asynchronous pins
	// ----------------------------------------------------------------
	logic [5:0] sync1_ff, sync2_ff;
	logic [2:0] prev_ff, lvl_hist_ff;
	logic [2:0] pend_ff, nxt_pend, clr;
	logic [2:0] lvl_in;
	logic irq_ok, sync_any;

	// first stage feeds only the second; edges seen on stage two
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			sync1_ff <= 6'h00;
			sync2_ff <= 6'h00;
			prev_ff <= 3'h0;
			lvl_hist_ff <= 3'h0;
			pend_ff <= 3'h0;
		end else begin
			sync1_ff <= {I_RST_REQ, I_BERR, I_BKPT, I_IRQ_LEVEL};
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff[5:3];
			lvl_hist_ff <= sync2_ff[2:0];
			pend_ff <= nxt_pend;
		end
	end

	// a new edge wins over a clear in the same cycle
	always_comb begin
		nxt_pend = (pend_ff & ~clr) | (sync2_ff[5:3] & ~prev_ff);
	end

	// level bits may settle in different clocks; take two matching samples
	assign lvl_in = (sync2_ff[2:0] == lvl_hist_ff) ? lvl_hist_ff : 3'h0;
	assign sync_any = |I_SYNC_REQ;

	// ----------------------------------------------------------------
	// sequencer state
	// ----------------------------------------------------------------
	ces_state_t state_ff, nxt_state;
	ces_bus_t bus_ff, nxt_bus;
	logic bcyc_ff, nxt_bcyc, wait_ff, nxt_wait, bdone;
	logic [23:0] ret_ff, nxt_ret, pc_ff, nxt_pc;
	logic [15:0] cc_ff, nxt_cc, sp_ff, nxt_sp, iz_ff, nxt_iz;
	logic [3:0] sbank_ff, nxt_sbank;
	logic [11:0] ext_ff, nxt_ext;
	logic [7:0] vec_ff, nxt_vec;
	logic [2:0] lvl_ff, nxt_lvl;
	logic [1:0] idx_ff, nxt_idx;
	logic iack_ff, nxt_iack, nest_ff, nxt_nest, hold_ff, nxt_hold;
	logic load_ff, nxt_load, rload_ff, nxt_rload, dbg_ff, nxt_dbg;
	logic [23:0] async_ret;

	// interrupts stay unseen until the handler's first instruction ends
	assign irq_ok = (lvl_in != 3'h0) && !hold_ff &&
		((lvl_in == `CES_IRQ_NMI) || (lvl_in > I_IRQ_MASK));
	// an ack earlier than the second clock is ignored
	assign bdone = bus_ff.req && bcyc_ff && (I_BUS_ACK || I_BUS_BERR);
	// a nested exception returns to the handler just loaded
	assign async_ret = nest_ff ? pc_ff + `CES_PREFETCH_ADJ : I_PC;

	always_comb begin
		nxt_state = state_ff;
		nxt_bus = bus_ff;
		nxt_bus.req = 1'b0;
		nxt_bcyc = bus_ff.req && !bdone;
		nxt_wait = 1'b0;
		nxt_ret = ret_ff;
		nxt_pc = pc_ff;
		nxt_cc = cc_ff;
		nxt_sp = sp_ff;
		nxt_iz = iz_ff;
		nxt_sbank = sbank_ff;
		nxt_ext = ext_ff;
		nxt_vec = vec_ff;
		nxt_lvl = lvl_ff;
		nxt_idx = idx_ff;
		nxt_iack = iack_ff;
		nxt_nest = nest_ff;
		nxt_hold = hold_ff;
		nxt_load = 1'b0;
		nxt_rload = 1'b0;
		nxt_dbg = 1'b0;
		clr = 3'h0;
		case (state_ff)
			ST_RESET: begin
				// four program-space words from the bottom of bank 0
				clr[2] = 1'b1;
				nxt_bus.req = !bdone;
				nxt_bus.wr = 1'b0;
				nxt_bus.prog = 1'b1;
				nxt_bus.iack = 1'b0;
				nxt_bus.addr = {21'h000000, idx_ff, 1'b0};
				if (bdone) begin
					case (idx_ff)
						2'h0: nxt_ext = I_BUS_RDATA[11:0];
						2'h1: nxt_pc = {ext_ff[3:0], I_BUS_RDATA};
						2'h2: nxt_sp = I_BUS_RDATA;
						default: nxt_iz = I_BUS_RDATA;
					endcase
					nxt_idx = idx_ff + 2'h1;
					if (idx_ff == `CES_RST_LAST_WORD) begin
						nxt_state = ST_IDLE;
						nxt_rload = 1'b1;
						nxt_sbank = ext_ff[7:4];
						nxt_nest = 1'b0;
						nxt_hold = 1'b0;
					end
				end
			end
			ST_IDLE: begin
				if (I_BOUNDARY) begin
					nxt_hold = 1'b0;
				end
				if (pend_ff[2]) begin
					nxt_state = ST_RESET;
					nxt_idx = 2'h0;
				end else if (I_BOUNDARY && (pend_ff[1] || pend_ff[0] ||
						irq_ok || sync_any)) begin
					nxt_state = ST_PRIO;
					nxt_nest = 1'b0;
				end
			end
			ST_PRIO: begin
				// phase one: pick the most urgent pending exception
				nxt_wait = !wait_ff;
				if (wait_ff) begin
					nxt_state = ST_PUSH_PC;
					nxt_iack = 1'b0;
					nxt_ret = async_ret;
					if (!nest_ff) begin
						nxt_sp = I_SP;
						nxt_sbank = I_STACK_BANK;
						nxt_cc = I_COND_CODES;
					end
					if (pend_ff[2]) begin
						nxt_state = ST_RESET;
						nxt_idx = 2'h0;
					end else if (pend_ff[1]) begin
						nxt_vec = `CES_VEC_BERR;
						clr[1] = 1'b1;
					end else if (pend_ff[0]) begin
						nxt_vec = `CES_VEC_BKPT;
						clr[0] = 1'b1;
					end else if (irq_ok && !nest_ff) begin
						nxt_iack = 1'b1;
						nxt_lvl = lvl_in;
					end else if (sync_any && !nest_ff) begin
						nxt_ret = I_PC + `CES_SYNC_ADJ;
						if (I_SYNC_REQ.trap) begin
							nxt_vec = `CES_VEC_TRAP;
						end else if (I_SYNC_REQ.illegal) begin
							nxt_vec = `CES_VEC_ILLEGAL;
						end else if (I_SYNC_REQ.divz) begin
							nxt_vec = `CES_VEC_DIVZ;
						end else begin
							nxt_state = ST_IDLE;
							nxt_dbg = 1'b1;
						end
					end else begin
						nxt_state = ST_IDLE;
					end
				end
			end
			ST_PUSH_PC, ST_PUSH_CC: begin
				// phase two: return address, then codes with bank nibble
				nxt_bus.req = !bdone;
				nxt_bus.wr = 1'b1;
				nxt_bus.prog = 1'b0;
				nxt_bus.iack = 1'b0;
				nxt_bus.addr = {sbank_ff, 4'h0, sp_ff};
				nxt_bus.wdata = (state_ff == ST_PUSH_PC) ? ret_ff[15:0] :
					{cc_ff[15:4], ret_ff[23:20]};
				if (bdone) begin
					nxt_sp = sp_ff - `CES_WORD_BYTES;
					nxt_state = (state_ff == ST_PUSH_PC) ? ST_PUSH_CC :
						ST_CLR_BANK;
				end
			end
			ST_CLR_BANK: begin
				nxt_wait = !wait_ff;
				if (wait_ff) begin
					nxt_pc[23:20] = 4'h0;
					nxt_cc[3:0] = 4'h0;
					nxt_state = iack_ff ? ST_IACK : ST_VECGEN;
				end
			end
			ST_IACK: begin
				// phase three: the interrupting device names its vector
				nxt_bus.req = !bdone;
				nxt_bus.wr = 1'b0;
				nxt_bus.prog = 1'b0;
				nxt_bus.iack = 1'b1;
				nxt_bus.addr = {21'h000000, lvl_ff};
				if (bdone) begin
					if (I_BUS_BERR) begin
						nxt_vec = `CES_VEC_SPURIOUS;
					end else if (I_BUS_AUTOVEC) begin
						nxt_vec = `CES_VEC_AUTO_BASE + {5'h00, lvl_ff};
					end else begin
						nxt_vec = I_BUS_RDATA[7:0];
					end
					nxt_state = ST_FETCH;
				end
			end
			ST_VECGEN: begin
				// vector already known; conversion costs two clocks
				nxt_wait = !wait_ff;
				if (wait_ff) begin
					nxt_state = ST_FETCH;
				end
			end
			ST_FETCH: begin
				// one data-space word inside the 512-byte table
				nxt_bus.req = !bdone;
				nxt_bus.wr = 1'b0;
				nxt_bus.prog = 1'b0;
				nxt_bus.iack = 1'b0;
				nxt_bus.addr = {15'h0000, vec_ff, 1'b0};
				if (bdone) begin
					nxt_pc = {4'h0, 4'h0, I_BUS_RDATA};
					nxt_state = ST_LOAD;
				end
			end
			ST_LOAD: begin
				// phase four, unless an urgent event preempts the handler
				if (pend_ff != 3'h0) begin
					nxt_state = ST_PRIO;
					nxt_nest = 1'b1;
				end else begin
					nxt_load = 1'b1;
					nxt_hold = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// register the sequencer; reset starts the four-word fetch
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			state_ff <= ST_RESET;
			bus_ff <= '0;
			bcyc_ff <= 1'b0;
			wait_ff <= 1'b0;
			ret_ff <= 24'h000000;
			pc_ff <= 24'h000000;
			cc_ff <= 16'h0000;
			sp_ff <= 16'h0000;
			iz_ff <= 16'h0000;
			sbank_ff <= 4'h0;
			ext_ff <= 12'h000;
			vec_ff <= 8'h00;
			lvl_ff <= 3'h0;
			idx_ff <= 2'h0;
			iack_ff <= 1'b0;
			nest_ff <= 1'b0;
			hold_ff <= 1'b0;
			load_ff <= 1'b0;
			rload_ff <= 1'b0;
			dbg_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			bus_ff <= nxt_bus;
			bcyc_ff <= nxt_bcyc;
			wait_ff <= nxt_wait;
			ret_ff <= nxt_ret;
			pc_ff <= nxt_pc;
			cc_ff <= nxt_cc;
			sp_ff <= nxt_sp;
			iz_ff <= nxt_iz;
			sbank_ff <= nxt_sbank;
			ext_ff <= nxt_ext;
			vec_ff <= nxt_vec;
			lvl_ff <= nxt_lvl;
			idx_ff <= nxt_idx;
			iack_ff <= nxt_iack;
			nest_ff <= nxt_nest;
			hold_ff <= nxt_hold;
			load_ff <= nxt_load;
			rload_ff <= nxt_rload;
			dbg_ff <= nxt_dbg;
		end
	end

	// ----------------------------------------------------------------
	// return adjustment and instruction clock accounting
	// ----------------------------------------------------------------
	logic ret_v_ff, nxt_ret_v;
	logic [23:0] ret_pc_ff, nxt_ret_pc;
	logic [CNT_W-1:0] p_ff, o_ff, i_ff, tot_ff;
	logic [CNT_W-1:0] nxt_p, nxt_o, nxt_i, nxt_tot;

	// counts restart on each start so only one instruction is summed
	always_comb begin
		nxt_ret_v = I_RETURN;
		nxt_ret_pc = I_RETURN ? I_RETURN_ADDR - `CES_PREFETCH_ADJ :
			ret_pc_ff;
		nxt_tot = tot_ff;
		nxt_p = p_ff + CNT_W'(I_TIMING.prog);
		nxt_o = o_ff + CNT_W'(I_TIMING.oper);
		nxt_i = i_ff + CNT_W'(I_TIMING.intl);
		if (I_TIMING.start) begin
			nxt_tot = p_ff + o_ff + i_ff;
			nxt_p = CNT_W'(I_TIMING.prog);
			nxt_o = CNT_W'(I_TIMING.oper);
			nxt_i = CNT_W'(I_TIMING.intl);
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			ret_v_ff <= 1'b0;
			ret_pc_ff <= 24'h000000;
			p_ff <= '0;
			o_ff <= '0;
			i_ff <= '0;
			tot_ff <= '0;
		end else begin
			ret_v_ff <= nxt_ret_v;
			ret_pc_ff <= nxt_ret_pc;
			p_ff <= nxt_p;
			o_ff <= nxt_o;
			i_ff <= nxt_i;
			tot_ff <= nxt_tot;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign O_BUS = bus_ff;
	assign O_BUSY = (state_ff != ST_IDLE); // holds the core off the handler
	assign O_LOAD = load_ff;
	assign O_RST_LOAD = rload_ff;
	assign O_DEBUG = dbg_ff;
	assign O_NEW_PC = pc_ff;
	assign O_NEW_SP = sp_ff;
	assign O_RST_EXT = ext_ff;
	assign O_RST_INDEX = iz_ff;
	assign O_VEC_NUM = vec_ff;
	assign O_RETURN_VALID = ret_v_ff;
	assign O_RETURN_PC = ret_pc_ff;
	assign O_INSN_CLKS = tot_ff;

endmodule // ces_sequencer

// ===== rtl/ces_params.svh
// constants of the exception sequencer: vectors, table layout, offsets
`ifndef CES_PARAMS_SVH
`define CES_PARAMS_SVH
// ----------------------------------------------------------------
// vector numbers and table
// ----------------------------------------------------------------
`define CES_VEC_BKPT 8'h04
`define CES_VEC_BERR 8'h05
`define CES_VEC_TRAP 8'h06
`define CES_VEC_ILLEGAL 8'h07
`define CES_VEC_DIVZ 8'h08
`define CES_VEC_UNINIT 8'h0f
`define CES_VEC_AUTO_BASE 8'h10
`define CES_VEC_SPURIOUS 8'h18
`define CES_VEC_USER_FIRST 8'h38
`define CES_TABLE_BYTES 512
`define CES_TABLE_ENTRIES 252
`define CES_RST_LAST_WORD 2'h3
// ----------------------------------------------------------------
// address adjustments and timing
// ----------------------------------------------------------------
`define CES_PREFETCH_ADJ 24'h000006
`define CES_SYNC_ADJ 24'h000002
`define CES_WORD_BYTES 16'h0002
`define CES_IRQ_NMI 3'h7
`define CES_MIN_BUS_CLKS 2
`define CES_INT_OP_CLKS 2
`endif

// ===== rtl/ces_pkg.sv
// types shared by the exception sequencer and its bench
package ces_pkg;
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_PRIO, ST_PUSH_PC, ST_PUSH_CC,
		ST_CLR_BANK, ST_IACK, ST_VECGEN, ST_FETCH, ST_LOAD
	} ces_state_t;
	typedef struct packed {
		logic req;
		logic wr;
		logic prog;
		logic iack;
		logic [23:0] addr;
		logic [15:0] wdata;
	} ces_bus_t;
	typedef struct packed {
		logic trap;
		logic debug;
		logic illegal;
		logic divz;
	} ces_sync_t;
	typedef struct packed {
		logic start;
		logic prog;
		logic oper;
		logic intl;
	} ces_timing_t;
endpackage

// ===== sim/ces_sequencer_checker.sv
// port assertions for the exception sequencer
`timescale 1ns/1ns
module ces_sequencer_checker
	import ces_pkg::*;
(
	// clock, reset and watched inputs
	input wire logic I_MCLK,
	input wire logic I_RESET,
	input wire logic I_BOUNDARY,
	input wire logic I_RETURN,
	input wire logic [23:0] I_RETURN_ADDR,
	input wire logic I_BUS_ACK,
	input wire logic [15:0] I_BUS_RDATA,
	// watched outputs
	input wire ces_bus_t O_BUS,
	input wire logic O_BUSY,
	input wire logic O_LOAD,
	input wire logic [23:0] O_NEW_PC,
	input wire logic O_RETURN_VALID,
	input wire logic [23:0] O_RETURN_PC
);
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_RESET);
	// data-space vector read ended by an accepted ack
	sequence s_vec_ack;
		O_BUS.req && $past(O_BUS.req) && !O_BUS.wr && !O_BUS.prog &&
			!O_BUS.iack && I_BUS_ACK;
	endsequence
	sequence s_vec_load;
		s_vec_ack ##2 O_LOAD;
	endsequence
	// bus cycles are never shorter than two clocks
	a_bus_min_len: assert property ($rose(O_BUS.req) |=> O_BUS.req)
		else $error("bus cycle shorter than two clocks");
	a_bus_addr_hold: assert property (O_BUS.req && $past(O_BUS.req) |->
		$stable(O_BUS.addr) && $stable(O_BUS.wr))
		else $error("bus request changed mid cycle");
	a_handler_load: assert property (s_vec_load |->
		O_NEW_PC == {8'h00, $past(I_BUS_RDATA, 2)})
		else $error("handler address not from vector word");
	a_handler_bank0: assert property (O_LOAD |->
		O_NEW_PC[23:16] == 8'h00)
		else $error("handler outside bank 0");
	a_vec_in_table: assert property (O_BUS.req && !O_BUS.wr && !O_BUS.prog &&
		!O_BUS.iack |-> O_BUS.addr[23:9] == 15'h0 && !O_BUS.addr[0])
		else $error("vector read outside table");
	a_reset_prog: assert property (O_BUS.req && O_BUS.prog |->
		!O_BUS.wr && O_BUS.addr <= 24'h6 && !O_BUS.addr[0])
		else $error("program read outside reset vector");
	a_return_adj: assert property (I_RETURN |=> O_RETURN_VALID &&
		O_RETURN_PC == $past(I_RETURN_ADDR) - 24'h6)
		else $error("return address not lowered by six");
	// only reset may start work away from a boundary
	a_busy_start: assert property ($rose(O_BUSY) && !$past(I_BOUNDARY) |->
		##[1:3] (O_BUS.req && O_BUS.prog))
		else $error("exception started off a boundary");
endmodule // ces_sequencer_checker

bind ces_sequencer ces_sequencer_checker u_chk (.I_MCLK(I_MCLK),
	.I_RESET(I_RESET), .I_BOUNDARY(I_BOUNDARY), .I_RETURN(I_RETURN),
	.I_RETURN_ADDR(I_RETURN_ADDR), .I_BUS_ACK(I_BUS_ACK),
	.I_BUS_RDATA(I_BUS_RDATA), .O_BUS(O_BUS), .O_BUSY(O_BUSY),
	.O_LOAD(O_LOAD), .O_NEW_PC(O_NEW_PC), .O_RETURN_VALID(O_RETURN_VALID),
	.O_RETURN_PC(O_RETURN_PC));

// ===== sim/ces_bus_model.sv
// bus responder standing in for the integration logic and memory
`timescale 1ns/1ns
module ces_bus_model
	import ces_pkg::*;
(
	// clock and bus from the sequencer
	input wire logic i_clk,
	input wire ces_bus_t i_bus,
	// answer shaping from the bench
	input wire logic [3:0] i_wait,
	input wire logic i_auto,
	input wire logic [7:0] i_vec,
	input wire logic i_fail,
	// answer
	output logic o_ack,
	output logic o_berr,
	output logic o_autovec,
	output logic [15:0] o_rdata
);
	logic [3:0] cnt = 4'h0;
	logic done = 1'b0;
	initial begin
		o_ack = 1'b0;
		o_berr = 1'b0;
		o_autovec = 1'b0;
		o_rdata = 16'h0;
	end
	// first counted clock is the one in which req rose, so ack is never early
	always @(posedge i_clk) begin
		#1;
		if (i_bus.req && !done && cnt == i_wait + 4'h1) begin
			done = 1'b1;
			o_berr = i_bus.iack && i_fail;
			o_ack = !(i_bus.iack && i_fail);
			o_autovec = i_bus.iack && i_auto;
			o_rdata = i_bus.iack ? {8'h00, i_vec} : i_bus.addr[15:0] ^ 16'ha5c3;
		end else begin
			o_ack = 1'b0;
			o_berr = 1'b0;
			o_autovec = 1'b0;
			o_rdata = ~o_rdata; // idle data never repeats the last word
			if (!i_bus.req) begin
				cnt = 4'h0;
				done = 1'b0;
			end else if (!done) begin
				cnt = cnt + 4'h1;
			end
		end
	end
endmodule // ces_bus_model

// ===== sim/tb_top.sv
// self-checking bench of the exception sequencer
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin num_checks++; \
	if ((got) !== (exp)) begin n_errors++; \
	$display("mismatch %0t %s", $time, msg); end end
module tb_top
	import ces_pkg::*;
;
	localparam logic [23:0] PC = 24'h301234;
	localparam logic [15:0] SP = 16'h0800;
	localparam logic [3:0] SB = 4'h1;
	localparam logic [15:0] CC = 16'hab50;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic rst_req = 1'b0;
	logic berr_pin = 1'b0;
	logic bkpt_pin = 1'b0;
	logic boundary = 1'b0;
	logic ret_req = 1'b0;
	logic use_auto = 1'b0;
	logic bus_fail = 1'b0;
	logic [2:0] irq_lvl = 3'h0;
	logic [2:0] irq_mask = 3'h7;
	logic [3:0] wait_n = 4'h0;
	logic [7:0] dev_vec = 8'h40;
	logic [23:0] ret_addr = 24'h0;
	ces_sync_t sync_req = '0;
	ces_timing_t timing = '0;
	ces_bus_t bus;
	logic ack, autovec, busy, load, rst_load, dbg, ret_valid, berr_ans;
	logic [15:0] rdata, new_sp, rst_index, insn_clks;
	logic [23:0] new_pc, ret_pc, ra, ia;
	logic [11:0] rst_ext;
	logic [7:0] vec_num;
	logic [23:0] wa[$];
	logic [15:0] wd[$];
	int n_prog = 0;
	int n_errors = 0;
	int num_checks = 0;
	initial begin
		forever #4 mclk = ~mclk;
	end
	ces_sequencer dut (.I_MCLK(mclk), .I_RESET(reset), .I_RST_REQ(rst_req),
		.I_BERR(berr_pin), .I_BKPT(bkpt_pin), .I_IRQ_LEVEL(irq_lvl),
		.I_BOUNDARY(boundary), .I_SYNC_REQ(sync_req), .I_IRQ_MASK(irq_mask),
		.I_PC(PC), .I_COND_CODES(CC), .I_SP(SP), .I_STACK_BANK(SB),
		.I_RETURN(ret_req), .I_RETURN_ADDR(ret_addr), .I_TIMING(timing),
		.O_BUS(bus), .I_BUS_ACK(ack), .I_BUS_BERR(berr_ans),
		.I_BUS_AUTOVEC(autovec), .I_BUS_RDATA(rdata), .O_BUSY(busy),
		.O_LOAD(load), .O_RST_LOAD(rst_load), .O_DEBUG(dbg),
		.O_NEW_PC(new_pc), .O_NEW_SP(new_sp), .O_RST_EXT(rst_ext),
		.O_RST_INDEX(rst_index), .O_VEC_NUM(vec_num),
		.O_RETURN_VALID(ret_valid), .O_RETURN_PC(ret_pc),
		.O_INSN_CLKS(insn_clks));
	ces_bus_model u_mem (.i_clk(mclk), .i_bus(bus), .i_wait(wait_n),
		.i_auto(use_auto), .i_vec(dev_vec), .i_fail(bus_fail),
		.o_ack(ack), .o_berr(berr_ans),
		.o_autovec(autovec), .o_rdata(rdata));
	// log every bus cycle ended by an ack (not by berr) by kind
	always @(posedge mclk) begin
		if (bus.req && ack) begin
			if (bus.wr) begin
				wa.push_back(bus.addr);
				wd.push_back(bus.wdata);
			end else if (bus.iack) ia = bus.addr;
			else if (bus.prog) n_prog++;
			else ra = bus.addr;
		end
	end
	task automatic tick();
		@(posedge mclk);
		#1;
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// which: 0 handler load, 1 debug entry, 2 reset load
	task automatic wait_for(input int which);
		int i;
		for (i = 0; i < 300; i++) begin
			tick();
			if ((which == 0 && load === 1'b1) || (which == 1 && dbg === 1'b1)
				|| (which == 2 && rst_load === 1'b1)) return;
		end
		$display("mismatch %0t timeout", $time);
		n_errors++;
		test_done();
	endtask
	task automatic pulse_bnd();
		boundary = 1'b1;
		tick();
		boundary = 1'b0;
	endtask
	// one exception pass, judged on its frame, vector and handler
	task automatic run_exc(input logic [7:0] vec, input logic [23:0] ret);
		wa.delete();
		wd.delete();
		pulse_bnd();
		wait_for(0);
		`CHK(wa.size(), 2, "frame size")
		`CHK(wa[0], {SB, 4'h0, SP}, "pc push address")
		`CHK(wd[0], ret[15:0], "stacked pc")
		`CHK(wa[1], {SB, 4'h0, SP - 16'h2}, "codes push address")
		`CHK(wd[1], {CC[15:4], ret[23:20]}, "stacked codes")
		`CHK(ra, {15'h0, vec, 1'b0}, "vector address")
		`CHK(vec_num, vec, "vector number")
		`CHK(new_pc, {8'h00, {7'h0, vec, 1'b0} ^ 16'ha5c3}, "handler")
		`CHK(new_sp, SP - 16'h4, "final sp")
	endtask
	task automatic t_reset();
		wait_for(2);
		`CHK(rst_ext, 12'h5c3, "extensions")
		`CHK(new_pc[19:0], 20'h3a5c1, "reset pc")
		`CHK(new_sp, 16'ha5c7, "reset sp")
		`CHK(rst_index, 16'ha5c5, "reset index")
		`CHK(n_prog, 4, "reset words")
		n_prog = 0;
		rst_req = 1'b1;
		repeat (4) tick();
		rst_req = 1'b0;
		wait_for(2);
		`CHK(n_prog, 4, "pin reset words")
		$display("test reset done");
	endtask
	task automatic t_sync();
		logic [7:0] vecs [3] = '{8'h06, 8'h07, 8'h08};
		int k;
		for (k = 0; k < 3; k++) begin
			sync_req.trap = (k == 0);
			sync_req.illegal = (k == 1);
			sync_req.divz = (k == 2);
			run_exc(vecs[k], PC + 24'h2);
			sync_req = '0;
			tick();
		end
		wa.delete();
		sync_req.debug = 1'b1;
		pulse_bnd();
		wait_for(1);
		sync_req = '0;
		`CHK(wa.size(), 0, "debug entry stacks nothing")
		$display("test sync done");
	endtask
	task automatic t_async();
		sync_req.illegal = 1'b1;
		bkpt_pin = 1'b1;
		repeat (4) tick();
		bkpt_pin = 1'b0;
		`CHK(busy, 1'b0, "waits for boundary")
		run_exc(8'h04, PC);
		run_exc(8'h07, PC + 24'h2);
		sync_req = '0;
		berr_pin = 1'b1;
		repeat (4) tick();
		berr_pin = 1'b0;
		run_exc(8'h05, PC);
		$display("test async done");
	endtask
	// masked level ignored, then autovector and device vector
	task automatic t_irq();
		irq_lvl = 3'h2;
		irq_mask = 3'h3;
		repeat (4) tick();
		pulse_bnd();
		repeat (3) tick();
		`CHK(busy, 1'b0, "masked level")
		use_auto = 1'b1;
		irq_mask = 3'h0;
		wait_n = 4'h2;
		run_exc(8'h12, PC);
		`CHK(ia, 24'h2, "iack level")
		irq_lvl = 3'h0;
		use_auto = 1'b0;
		repeat (4) tick();
		pulse_bnd();
		irq_lvl = 3'h5;
		repeat (4) tick();
		run_exc(8'h40, PC);
		`CHK(ia, 24'h5, "iack level")
		// a refused acknowledge falls back to the spurious vector
		pulse_bnd();
		tick();
		bus_fail = 1'b1;
		run_exc(8'h18, PC);
		bus_fail = 1'b0;
		irq_lvl = 3'h0;
		wait_n = 4'h0;
		repeat (4) tick();
		pulse_bnd();
		$display("test irq done");
	endtask
	// breakpoint raised mid-pass preempts the trap handler's first step
	task automatic t_nest();
		wa.delete();
		wd.delete();
		sync_req.trap = 1'b1;
		pulse_bnd();
		bkpt_pin = 1'b1;
		wait_for(0);
		sync_req = '0;
		bkpt_pin = 1'b0;
		`CHK(wa.size(), 4, "nested frame size")
		`CHK(wa[2], {SB, 4'h0, SP - 16'h4}, "nested push address")
		`CHK(wd[2], 16'ha5d5, "nested return")
		`CHK(wd[3], {CC[15:4], 4'h0}, "nested codes")
		`CHK(vec_num, 8'h04, "nested vector")
		`CHK(new_pc, 24'h00a5cb, "nested handler")
		`CHK(new_sp, SP - 16'h8, "nested sp")
		$display("test nested done");
	endtask
	task automatic t_ret_time();
		ret_addr = 24'h123456;
		ret_req = 1'b1;
		tick();
		ret_req = 1'b0;
		`CHK(ret_valid, 1'b1, "return valid")
		`CHK(ret_pc, 24'h123450, "return pc")
		timing.start = 1'b1;
		tick();
		timing = '{start: 1'b0, prog: 1'b1, oper: 1'b0, intl: 1'b0};
		repeat (2) tick();
		timing = '{start: 1'b0, prog: 1'b0, oper: 1'b1, intl: 1'b0};
		repeat (3) tick();
		timing = '{start: 1'b0, prog: 1'b0, oper: 1'b0, intl: 1'b1};
		repeat (2) tick();
		timing = '{start: 1'b1, prog: 1'b0, oper: 1'b0, intl: 1'b0};
		tick();
		timing = '0;
		tick();
		`CHK(insn_clks, 16'h0007, "instruction clocks")
		$display("test return and timing done");
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge mclk);
		#1;
		reset = 1'b0;
		t_reset();
		t_sync();
		t_async();
		t_nest();
		t_irq();
		t_ret_time();
		test_done();
	end
endmodule // tb_top
